// File: rtl/rcfe_map.vh
// Address map, field layout, mode codes and reset values of the receive front end
`ifndef RCFE_MAP_VH
`define RCFE_MAP_VH

// Register port
`define RCFE_ADDR_W 11
`define RCFE_TBL_MASK 11'h400
`define RCFE_TBL_BASE 11'h000
`define RCFE_MODE_MASK 11'h7E0
`define RCFE_MODE_BASE 11'h400
`define RCFE_THR_ADDR 11'h420
`define RCFE_STAT_ADDR 11'h421
`define RCFE_LB_MASK 11'h7F8
`define RCFE_LB_BASE 11'h428

// Table word fields
`define RCFE_TW_EN 8
`define RCFE_TW_CHAN_HI 7
`define RCFE_TW_CHAN_LO 0

// Link modes
`define RCFE_MODE_CHAN 2'h0
`define RCFE_MODE_UNCH 2'h1
`define RCFE_MODE_HMV2 2'h2
`define RCFE_MODE_HMV8 2'h3

// Reset values
`define RCFE_MODE_RST 2'h0
`define RCFE_THR_RST 8'h20
`define RCFE_LB_RST 32'h0000_0000

// Arbiter null slot, one in every four cycles
`define RCFE_NULL_PHASE 2'h3

`endif

// File: rtl/rcfe_rx_front_end.v
// Receive link front end: deserialisers, slot tracking, arbiter, channel lookup
`timescale 1ns/100ps
`include "rcfe_map.vh"
// Notes on behaviour
// R1 - Thirty-two links, four selectable link modes
// R2 - 2.048 H-MVIP: groups of eight share clock
// R3 - 8.192 links 4m share clocks and pulse
// R4 - Software sets 4m+1..4m+3 to 8.192 too
// R5 - 128 slots spread over four internal links
// R6 - Inputs of 4m+1..4m+3 ignored then
// R7 - H-MVIP clocks halved; others used directly
// R8 - Frame pulse sampled by data/pulse clock
// R9 - Frame of 32 or 128 slots
// R10 - Bytes leave one at a time
// R11 - Fixed priority, link 0 highest
// R12 - Two sub-blocks, inactive one held reset
// R13 - Shift, load holding register, request, acknowledge
// R14 - Slot counter advances; pulse reinitialises it
// R15 - Clock gap threshold marks channelised framing
// R16 - Unchannelised: slot and activity held reset
// R17 - Channel from link and slot lookup
// R18 - Unchannelised channel from link alone
// R19 - Loopback substitutes transmit data, not H-MVIP
// R20 - Sources keep link rates within limits
// R21 - Registered requests, idle, null every fourth
// R22 - 1024-word table: channel and enable
// R23 - Byte load coincides with bit counter wrap
module rcfe_rx_front_end #(
    parameter NLINK = 32,
    parameter ACT_W = 8
) (
    // System
    input wire clk_sys,
    input wire arst_n,
    // Independent links
    input wire [31:0] rx_clk,
    input wire [31:0] rx_data,
    // 2.048 H-MVIP groups
    input wire [3:0] group_data_clock,
    input wire [3:0] group_frame_pulse_n,
    // 8.192 H-MVIP shared
    input wire fast_data_clock,
    input wire fast_frame_pulse_clock,
    input wire fast_frame_pulse_n,
    // Loopback data from transmit side
    input wire [7:0] tx_loop_data,
    // Register port
    input wire [10:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    // Byte stream to packet processor
    output reg byte_valid_q,
    output reg [7:0] byte_data_q,
    output reg [4:0] byte_link_q,
    output reg [4:0] byte_slot_q,
    output reg [7:0] byte_chan_q,
    output reg null_cycle_q,
    output reg loop_take_q
);

    localparam [ACT_W-1:0] ACT_ONE = {{(ACT_W-1){1'b0}}, 1'b1};

    // Channelised and 2.048 frames wrap at 32 slots
    function [6:0] f_ts_next;
        input [6:0] ts;
        input [1:0] md;
        begin
            if (md == `RCFE_MODE_UNCH)
                f_ts_next = 7'h00;
            else if (md == `RCFE_MODE_HMV8)
                f_ts_next = ts + 7'h01;
            else
                f_ts_next = {2'h0, ts[4:0] + 5'h01};
        end
    endfunction

    // Internal link and slot a held byte belongs to
    function [9:0] f_dest;
        input [4:0] ln;
        input [6:0] ts;
        input hm8;
        begin
            if (hm8)
                f_dest = {ln[4:2], ts[6:5], ts[4:0]};
            else
                f_dest = {ln, ts[4:0]};
        end
    endfunction

    // Reset release
    reg rst_a_q;
    reg rst_n;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_a_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_n <= rst_a_q;
        end
    end

    // Configuration state
    reg [1:0] mode_q [0:31];
    reg [ACT_W-1:0] thr_q;
    reg [31:0] lb_q [0:7];
    reg [8:0] tbl_q [0:1023];

    wire [NLINK-1:0] req_w;
    wire [NLINK-1:0] ack_w;
    wire [NLINK-1:0] frm_w;
    wire [NLINK-1:0] unch_w;
    wire [NLINK-1:0] hmv_w;
    wire [8*NLINK-1:0] hold_w;
    wire [10*NLINK-1:0] dest_w;

    // Register decode; a mode write also clears the framed status bit of the link it writes
    wire tbl_hit = (reg_addr & `RCFE_TBL_MASK) == `RCFE_TBL_BASE;
    wire mode_hit = (reg_addr & `RCFE_MODE_MASK) == `RCFE_MODE_BASE;
    wire lb_hit = (reg_addr & `RCFE_LB_MASK) == `RCFE_LB_BASE;
    wire [31:0] mwr_w = (reg_wr & mode_hit) ? (32'h0000_0001 << reg_addr[4:0]) : 32'h0000_0000;

    // Link clock edges; inputs are synchronous to clk_sys
    reg [31:0] rck_q;
    reg [3:0] gck_q;
    reg [3:0] gdiv_q;
    reg fck_q;
    reg fdiv_q;
    reg fpck_q;
    wire [31:0] rck_rise = rx_clk & ~rck_q;
    wire [3:0] gck_rise = group_data_clock & ~gck_q;
    wire [3:0] gfp_ev = gck_rise & ~group_frame_pulse_n; // R8
    wire [3:0] g_stb = gck_rise & ~gdiv_q & ~gfp_ev; // R7
    wire fck_rise = fast_data_clock & ~fck_q;
    wire ffp_ev = fast_frame_pulse_clock & ~fpck_q & ~fast_frame_pulse_n; // R8
    wire f_stb = fck_rise & ~fdiv_q; // R7

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rck_q <= 32'h0000_0000;
            gck_q <= 4'h0;
            gdiv_q <= 4'h0;
            fck_q <= 1'b0;
            fdiv_q <= 1'b0;
            fpck_q <= 1'b0;
        end else begin
            rck_q <= rx_clk;
            gck_q <= group_data_clock;
            fck_q <= fast_data_clock;
            fpck_q <= fast_frame_pulse_clock;
            // Pulse aligns the divider so the next edge carries the MSB
            gdiv_q <= (gdiv_q ^ gck_rise) & ~gfp_ev; // R7
            if (ffp_ev)
                fdiv_q <= 1'b0;
            else if (fck_rise)
                fdiv_q <= ~fdiv_q; // R7
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NLINK; gi = gi + 1) begin : g_link
            localparam integer LNI = gi;
            wire [4:0] ln_w = LNI[4:0];
            localparam LEAD = (gi % 4) == 0;
            wire [1:0] md = mode_q[gi];
            wire hm = md[1];
            wire hm8 = md == `RCFE_MODE_HMV8;
            wire chan = md == `RCFE_MODE_CHAN;
            wire c_rise = rck_rise[gi];
            // Non-lead links in fast mode see no strobes at all
            wire h_stb = hm8 ? (LEAD & f_stb) : g_stb[gi / 8]; // R2 R3 R6
            wire h_fp = hm8 ? (LEAD & ffp_ev) : gfp_ev[gi / 8]; // R2 R3
            reg [ACT_W-1:0] act_q;
            wire act_hit = chan & ~c_rise & (act_q + ACT_ONE == thr_q); // R15
            wire [1:0] act_en = {hm, ~hm}; // R12
            wire [1:0] stb = {h_stb, c_rise};
            wire [1:0] ini = {h_fp, act_hit};
            reg [7:0] sh_q [0:1];
            reg [2:0] bc_q [0:1];
            reg [6:0] ts_q [0:1];
            reg [7:0] hd_q [0:1];
            reg [6:0] hts_q [0:1];
            reg [1:0] rq_q;
            reg frm_q;
            integer s;

            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    act_q <= {ACT_W{1'b0}};
                    rq_q <= 2'h0;
                    frm_q <= 1'b0;
                    for (s = 0; s < 2; s = s + 1) begin
                        sh_q[s] <= 8'h00;
                        bc_q[s] <= 3'h0;
                        ts_q[s] <= 7'h00;
                        hd_q[s] <= 8'h00;
                        hts_q[s] <= 7'h00;
                    end
                end else begin
                    if (!chan || c_rise)
                        act_q <= {ACT_W{1'b0}}; // R15 R16
                    else if (act_q != thr_q)
                        act_q <= act_q + ACT_ONE; // R15
                    frm_q <= (frm_q & ~mwr_w[gi]) | (ini[hm] & act_en[hm]);
                    for (s = 0; s < 2; s = s + 1) begin
                        if (!act_en[s]) begin
                            sh_q[s] <= 8'h00; // R12
                            bc_q[s] <= 3'h0;
                            ts_q[s] <= 7'h00;
                            hd_q[s] <= 8'h00;
                            hts_q[s] <= 7'h00;
                            rq_q[s] <= 1'b0;
                        end else begin
                            if (ack_w[gi])
                                rq_q[s] <= 1'b0; // R13
                            if (ini[s]) begin
                                bc_q[s] <= 3'h0; // R14 R15
                                ts_q[s] <= 7'h00;
                            end else if (stb[s]) begin
                                sh_q[s] <= {sh_q[s][6:0], rx_data[gi]}; // R13
                                bc_q[s] <= bc_q[s] + 3'h1; // R23
                                if (bc_q[s] == 3'h7) begin
                                    hd_q[s] <= {sh_q[s][6:0], rx_data[gi]}; // R13 R23
                                    hts_q[s] <= ts_q[s];
                                    rq_q[s] <= 1'b1; // Load beats acknowledge
                                    ts_q[s] <= f_ts_next(ts_q[s], md); // R9 R14 R16
                                end
                            end
                        end
                    end
                end
            end

            // Only the active sub-block is visible to the arbiter
            assign req_w[gi] = rq_q[hm];
            assign hold_w[8*gi +: 8] = hd_q[hm];
            assign dest_w[10*gi +: 10] = f_dest(ln_w, hts_q[hm], hm8); // R5
            assign frm_w[gi] = frm_q;
            assign unch_w[gi] = md == `RCFE_MODE_UNCH;
            assign hmv_w[gi] = hm;
        end
    endgenerate

    // Arbiter: requests are already registered per link
    reg [1:0] phase_q;
    reg [4:0] sel;
    reg any;
    reg [5:0] k;
    wire null_w = phase_q == `RCFE_NULL_PHASE; // R21

    always @* begin
        sel = 5'h00;
        any = 1'b0;
        for (k = 6'h00; k < 6'h20; k = k + 6'h01) begin
            if (req_w[k[4:0]] && !any) begin
                sel = k[4:0]; // R11
                any = 1'b1;
            end
        end
    end

    // No grant in the null slot; downstream owns that cycle for host access
    wire grant = any & ~null_w; // R21
    assign ack_w = grant ? (32'h0000_0001 << sel) : 32'h0000_0000; // R13

    wire [9:0] g_dest = dest_w[10*sel +: 10];
    wire g_unch = unch_w[sel];
    wire [9:0] taddr = g_unch ? {g_dest[9:5], 5'h00} : g_dest; // R17 R18 R22
    wire [8:0] tword = tbl_q[taddr];
    wire [7:0] g_chan = tword[`RCFE_TW_CHAN_HI:`RCFE_TW_CHAN_LO];
    wire g_en = g_unch | tword[`RCFE_TW_EN]; // R17 R18
    wire [31:0] lb_word = lb_q[g_chan[7:5]];
    wire g_lb = ~hmv_w[sel] & lb_word[g_chan[4:0]]; // R19

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
            byte_valid_q <= 1'b0;
            byte_data_q <= 8'h00;
            byte_link_q <= 5'h00;
            byte_slot_q <= 5'h00;
            byte_chan_q <= 8'h00;
            null_cycle_q <= 1'b0;
            loop_take_q <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1; // R21
            null_cycle_q <= null_w; // R21
            byte_valid_q <= grant & g_en; // R10
            loop_take_q <= grant & g_en & g_lb; // R19
            // Dropped slots leave the last delivered fields standing
            if (grant && g_en) begin
                // Looped channel drops line data in favour of transmit data
                byte_data_q <= g_lb ? tx_loop_data : hold_w[8*sel +: 8]; // R19
                byte_link_q <= g_dest[9:5]; // R5
                byte_slot_q <= g_dest[4:0];
                byte_chan_q <= g_chan; // R17
            end
        end
    end

    // Register port
    integer j;

    // Table has no reset; software provisions it before enabling links
    always @(posedge clk_sys) begin
        if (reg_wr && tbl_hit)
            tbl_q[reg_addr[9:0]] <= reg_wdata[8:0]; // R22
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            thr_q <= `RCFE_THR_RST;
            for (j = 0; j < 32; j = j + 1)
                mode_q[j] <= `RCFE_MODE_RST;
            for (j = 0; j < 8; j = j + 1)
                lb_q[j] <= `RCFE_LB_RST;
            reg_rdata_q <= 32'h0000_0000;
        end else begin
            if (reg_wr && mode_hit)
                mode_q[reg_addr[4:0]] <= reg_wdata[1:0]; // R1 R4
            if (reg_wr && reg_addr == `RCFE_THR_ADDR)
                thr_q <= reg_wdata[ACT_W-1:0]; // R15
            if (reg_wr && lb_hit)
                lb_q[reg_addr[2:0]] <= reg_wdata;
            reg_rdata_q <= 32'h0000_0000;
            if (reg_rd) begin
                if (tbl_hit)
                    reg_rdata_q <= {23'h000000, tbl_q[reg_addr[9:0]]};
                else if (mode_hit)
                    reg_rdata_q <= {30'h00000000, mode_q[reg_addr[4:0]]};
                else if (reg_addr == `RCFE_THR_ADDR)
                    reg_rdata_q <= {{(32-ACT_W){1'b0}}, thr_q};
                else if (reg_addr == `RCFE_STAT_ADDR)
                    reg_rdata_q <= frm_w;
                else if (lb_hit)
                    reg_rdata_q <= lb_q[reg_addr[2:0]];
            end
        end
    end

endmodule

// File: verif/rcfe_link_src.sv
// Line source model: per-link clock and serial data
`timescale 1ns/100ps
module rcfe_link_src (
    // System
    input wire clk_sys,
    // Link pins
    output reg [31:0] rx_clk,
    output reg [31:0] rx_data,
    // 2.048 H-MVIP group pins
    output reg [3:0] group_data_clock,
    output reg [3:0] group_frame_pulse_n
);
    initial begin
        rx_clk = 32'h0;
        rx_data = 32'h0;
        group_data_clock = 4'h0;
        group_frame_pulse_n = 4'hF;
    end
    // Two bytes MSB first; clock stands low between calls
    task send(input [31:0] lm, input [15:0] d);
        int i;
        for (i = 15; i >= 0; i--) begin
            @(posedge clk_sys);
            rx_data <= (rx_data & ~lm) | (d[i] ? lm : 32'h0);
            repeat (3) @(posedge clk_sys);
            // Eight cycle bit period, far below the rate ceiling
            rx_clk <= rx_clk | lm;
            repeat (4) @(posedge clk_sys);
            rx_clk <= rx_clk & ~lm;
            // Hold over: line shows the inverse, not a stale bit
            rx_data <= rx_data ^ lm;
        end
    endtask
    // One group clock period: two cycles low, two high
    task gtick;
        repeat (2) @(posedge clk_sys);
        group_data_clock <= 4'h1;
        repeat (2) @(posedge clk_sys);
        group_data_clock <= 4'h0;
    endtask
    // Frame pulse on group 0, then two bytes on link 0, one bit per two clocks
    task hsend(input [15:0] d);
        int i;
        @(posedge clk_sys);
        group_frame_pulse_n <= 4'hE;
        gtick;
        group_frame_pulse_n <= 4'hF;
        for (i = 15; i >= 0; i--) begin
            rx_data <= {rx_data[31:1], d[i]};
            gtick;
            gtick;
        end
    endtask
endmodule

// File: verif/rcfe_props.sv
// Port checker for the receive front end
`timescale 1ns/100ps
`include "rcfe_map.vh"
module rcfe_props #(
    parameter NLINK = 32,
    parameter ACT_W = 8
) (
    input wire clk_sys,
    input wire arst_n,
    input wire [10:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_q,
    input wire byte_valid_q,
    input wire [7:0] byte_data_q,
    input wire [4:0] byte_link_q,
    input wire [4:0] byte_slot_q,
    input wire [7:0] byte_chan_q,
    input wire null_cycle_q,
    input wire loop_take_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata_q == 32'h0) else $error("read data outside slot");
    a_null_no_byte: assert property (
        null_cycle_q |-> !byte_valid_q) else $error("byte after null slot");
    a_null_period: assert property (
        null_cycle_q |=> !null_cycle_q [*3] ##1 null_cycle_q) else $error("null spacing");
    a_loop_with_byte: assert property (
        loop_take_q |-> byte_valid_q) else $error("loop take without byte");
    a_fields_stable: assert property (
        !byte_valid_q |-> $stable({byte_data_q, byte_link_q, byte_slot_q, byte_chan_q}))
        else $error("byte fields moved");
    a_mode_width: assert property (
        reg_rd && ((reg_addr & `RCFE_MODE_MASK) == `RCFE_MODE_BASE)
        |=> reg_rdata_q[31:2] == 30'h0) else $error("mode read too wide");
    a_table_echo: assert property (
        reg_wr && ((reg_addr & `RCFE_TBL_MASK) == `RCFE_TBL_BASE)
        ##1 reg_rd && reg_addr == $past(reg_addr)
        |=> reg_rdata_q == ($past(reg_wdata, 2) & 32'h0000_01FF)) else $error("table echo");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr == 11'h7FF |=> reg_rdata_q == 32'h0) else $error("unmapped read");
endmodule
bind rcfe_rx_front_end rcfe_props #(.NLINK(NLINK), .ACT_W(ACT_W)) i_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .byte_valid_q(byte_valid_q), .byte_data_q(byte_data_q), .byte_link_q(byte_link_q),
    .byte_slot_q(byte_slot_q), .byte_chan_q(byte_chan_q), .null_cycle_q(null_cycle_q),
    .loop_take_q(loop_take_q));

// File: verif/rx_link_channel_front_end_tb.sv
// Self-checking bench for the receive front end
`timescale 1ns/100ps
module rx_link_channel_front_end_tb;
    logic clk_sys, arst_n, reg_wr, reg_rd, byte_valid_q, null_cycle_q, loop_take_q;
    logic [31:0] rx_clk, rx_data, reg_wdata, reg_rdata_q, rv;
    logic [10:0] reg_addr;
    logic [7:0] tx_loop_data, byte_data_q, byte_chan_q, ch;
    logic [4:0] byte_link_q, byte_slot_q;
    logic [8:0] tbl [0:1023];
    logic [255:0] lb;
    logic [15:0] dd;
    logic [3:0] group_data_clock, group_frame_pulse_n;
    logic hmv;
    logic [9:0] ta;
    int err_count = 0, num_checks = 0, cyc = 0, i, s;

    rcfe_link_src i_src (.clk_sys(clk_sys), .rx_clk(rx_clk), .rx_data(rx_data),
        .group_data_clock(group_data_clock), .group_frame_pulse_n(group_frame_pulse_n));
    rcfe_rx_front_end #(.NLINK(32), .ACT_W(8)) i_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .rx_clk(rx_clk), .rx_data(rx_data),
        .group_data_clock(group_data_clock), .group_frame_pulse_n(group_frame_pulse_n),
        .fast_data_clock(1'b0),
        .fast_frame_pulse_clock(1'b0), .fast_frame_pulse_n(1'b1),
        .tx_loop_data(tx_loop_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .byte_valid_q(byte_valid_q), .byte_data_q(byte_data_q), .byte_link_q(byte_link_q),
        .byte_slot_q(byte_slot_q), .byte_chan_q(byte_chan_q), .null_cycle_q(null_cycle_q),
        .loop_take_q(loop_take_q));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test;
        end
    end
    task chk_reg(input [31:0] e, input [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %0t exp %h got %h", $time, e, g);
        end
    endtask
    task chk_byte(input [27:0] e, input [27:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %0t exp %h got %h", $time, e, g);
        end
    endtask
    task wr(input [10:0] a, input [31:0] w);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input [10:0] a, output [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    // Write then read back at once; exercises the no-wait slave
    task wrrd(input [10:0] a, input [31:0] w, output [31:0] d);
        wr(a, w);
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    function automatic [27:0] exp_byte(input [4:0] ln, input [4:0] sl, input [7:0] d);
        logic [7:0] c;
        logic lp;
        c = tbl[{ln, sl}][7:0];
        // No loopback on H-MVIP links
        lp = lb[c] & ~hmv;
        exp_byte = {1'b1, lp, lp ? tx_loop_data : d, ln, sl, c};
    endfunction
    task wait_byte(input [4:0] ln, input [4:0] sl, input [7:0] d);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (byte_valid_q !== 1'b1 && n < 300);
        chk_byte(exp_byte(ln, sl, d), {byte_valid_q, loop_take_q, byte_data_q,
            byte_link_q, byte_slot_q, byte_chan_q});
    endtask
    // Gap longer than the threshold, then two bytes on the masked links
    task burst(input [31:0] lm, input [4:0] l0, input [4:0] l1, input [4:0] s1);
        dd = 16'($urandom);
        repeat (40) @(posedge clk_sys);
        fork
            if (hmv) i_src.hsend(dd);
            else i_src.send(lm, dd);
            begin
                wait_byte(l0, 5'h0, dd[15:8]);
                if (l1 != l0) wait_byte(l1, 5'h0, dd[15:8]);
                wait_byte(l0, s1, dd[7:0]);
                if (l1 != l0) wait_byte(l1, s1, dd[7:0]);
            end
        join
    endtask

    initial begin
        rv = $urandom(32'h3bf9b858);
        arst_n = 1'b0;
        reg_addr = 11'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tx_loop_data = 8'h0;
        lb = 256'h0;
        hmv = 1'b0;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(11'h420, rv);
        chk_reg(32'h20, rv);
        rd(11'h402, rv);
        chk_reg(32'h0, rv);
        rd(11'h7FF, rv);
        chk_reg(32'h0, rv);
        for (i = 0; i < 3; i++) for (s = 0; s < 2; s++) begin
            ta = {5'(i), 5'(s)};
            tbl[ta] = {1'b1, 8'($urandom)};
            wrrd({1'b0, ta}, {23'h0, tbl[ta]}, rv);
            chk_reg({23'h0, tbl[ta]}, rv);
        end
        wr(11'h420, 32'h18);
        wr(11'h400, 32'h0);
        wr(11'h401, 32'h0);
        rd(11'h421, rv);
        chk_reg(32'h0, rv & 32'h3);
        burst(32'h3, 5'd0, 5'd1, 5'd1);
        // Gap past the new threshold but short of the reset one
        repeat (24) @(posedge clk_sys);
        rd(11'h421, rv);
        chk_reg(32'h3, rv & 32'h3);
        wr(11'h402, 32'h1);
        rd(11'h402, rv);
        chk_reg(32'h1, rv);
        burst(32'h4, 5'd2, 5'd2, 5'd0);
        @(posedge clk_sys);
        tx_loop_data <= 8'($urandom);
        ch = tbl[0][7:0];
        lb[ch] = 1'b1;
        wr(11'h428 + ch[7:5], 32'h1 << ch[4:0]);
        burst(32'h1, 5'd0, 5'd0, 5'd1);
        wr(11'h400, 32'h2);
        rd(11'h421, rv);
        chk_reg(32'h0, rv & 32'h1);
        hmv = 1'b1;
        burst(32'h1, 5'd0, 5'd0, 5'd1);
        rd(11'h421, rv);
        chk_reg(32'h1, rv & 32'h1);
        for (i = 4; i < 8; i++) wr(11'h400 + 11'(i), 32'h3);
        rd(11'h407, rv);
        chk_reg(32'h3, rv);
        end_of_test;
    end
endmodule
